// ==== rtl/bsc_top.sv ====
// frame-level switching control: counters, extension choice, transition actions
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic frame_stb,
   input wire bsc_pkg::bsc_frame_s frame_in,
   output logic busy,
   output logic rate_stb,
   output bsc_pkg::bsc_rate_act_s rate_act,
   output logic mode_stb,
   output bsc_pkg::bsc_mode_act_s mode_act,
   output logic frame_done,
   output bsc_pkg::bsc_cnt_s cnt
);
   typedef struct packed {
      bsc_pkg::bsc_phase_e phase;
      logic first_n;
      bsc_pkg::bsc_frame_s cur;
      bsc_pkg::bsc_band_e prev_bw;
      logic [16:0] prev_br;
      logic [1:0] prev_int_rate;
      bsc_pkg::bsc_core_e prev_core;
      logic prev_pf_applied;
      logic prev_legacy;
      logic pend_mode_trans;
      logic pend_core_resample;
      logic busy;
      logic rate_stb;
      bsc_pkg::bsc_rate_act_s rate_act;
      logic mode_stb;
      bsc_pkg::bsc_mode_act_s mode_act;
      logic frame_done;
   } bsc_state_s;

   bsc_state_s s_q;
   bsc_state_s s_d;
   logic step;
   bsc_pkg::bsc_ext_e ext_sel;

   // every check in this module runs on the one frame clock
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   function automatic logic bpf_clear_rate(input logic [16:0] br);
      return br == `BSC_BR_9600 || br == `BSC_BR_16400 || br == `BSC_BR_24400;
   endfunction

   // a strobe is taken only when idle; later ones are ignored until done
   assign step = frame_stb && s_q.phase == bsc_pkg::BSC_PH_IDLE;

   bsc_counters u_counters (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .step(step),
      .cur_bw(frame_in.bw),
      .prev_bw(s_q.prev_bw),
      .cur_br(frame_in.total_br),
      .prev_br(s_q.prev_br),
      .cnt_q(cnt)
   );

   bsc_ext_sel u_ext_sel (
      .frame(s_q.cur),
      .w2n(cnt.w2n),
      .ext_mode(ext_sel)
   );

   always_comb begin
      logic rate_sw;
      logic pf_used;
      rate_sw = 1'b0;
      pf_used = 1'b0;
      s_d = s_q;
      s_d.rate_stb = 1'b0;
      s_d.mode_stb = 1'b0;
      s_d.frame_done = 1'b0;
      unique case (s_q.phase)
         bsc_pkg::BSC_PH_IDLE: begin
            if (frame_stb) begin
               // first frame after reset has no history to switch from
               rate_sw = s_q.first_n && frame_in.int_rate != s_q.prev_int_rate;
               s_d.cur = frame_in;
               s_d.busy = 1'b1;
               s_d.rate_stb = 1'b1;
               s_d.rate_act.reconfig = s_q.first_n &&
                  frame_in.total_br != s_q.prev_br;
               s_d.rate_act.apf_resample = rate_sw && s_q.prev_pf_applied;
               s_d.rate_act.apf_bypass = rate_sw && !s_q.prev_pf_applied &&
                  frame_in.pf_on;
               s_d.rate_act.apf_fill_mem = rate_sw && !s_q.prev_pf_applied &&
                  frame_in.pf_on;
               s_d.rate_act.apf_smooth_first = s_q.prev_pf_applied &&
                  !frame_in.pf_on;
               s_d.rate_act.bpf_mem_clear = rate_sw &&
                  bpf_clear_rate(frame_in.total_br);
               s_d.rate_act.fb_resample_dec = rate_sw;
               s_d.rate_act.fb_resample_err = rate_sw;
               s_d.rate_act.legacy_clear_uv = frame_in.legacy && !s_q.prev_legacy;
               s_d.rate_act.legacy_clear_ext = frame_in.legacy && !s_q.prev_legacy;
               s_d.rate_act.bpf_disable = frame_in.legacy && !s_q.prev_legacy;
               s_d.rate_act.fpf_disable = frame_in.legacy && !s_q.prev_legacy;
               // mode work is held back until the rate work has been issued
               s_d.pend_mode_trans = s_q.first_n && frame_in.core != s_q.prev_core;
               s_d.pend_core_resample = rate_sw &&
                  s_q.prev_core == bsc_pkg::BSC_ALGEBRAIC_CORE &&
                  frame_in.core == bsc_pkg::BSC_TRANSFORM_EXCITED_CORE;
               pf_used = frame_in.pf_on && !(rate_sw && !s_q.prev_pf_applied) &&
                  !(frame_in.legacy && !s_q.prev_legacy);
               s_d.prev_pf_applied = pf_used;
               s_d.prev_bw = frame_in.bw;
               s_d.prev_br = frame_in.total_br;
               s_d.prev_int_rate = frame_in.int_rate;
               s_d.prev_core = frame_in.core;
               s_d.prev_legacy = frame_in.legacy;
               s_d.first_n = 1'b1;
               s_d.phase = bsc_pkg::BSC_PH_RATE;
            end
         end
         bsc_pkg::BSC_PH_RATE: begin
            s_d.mode_stb = 1'b1;
            s_d.frame_done = 1'b1;
            s_d.mode_act.mode_trans = s_q.pend_mode_trans;
            s_d.mode_act.past_core_resample = s_q.pend_core_resample;
            s_d.mode_act.ext_mode = ext_sel;
            s_d.mode_act.gain_num = `BSC_W2N_LIM - cnt.w2n;
            s_d.mode_act.down_active = cnt.w2n != '0;
            s_d.mode_act.up_active = cnt.n2w != '0;
            s_d.phase = bsc_pkg::BSC_PH_MODE;
         end
         bsc_pkg::BSC_PH_MODE: begin
            s_d.busy = 1'b0;
            s_d.phase = bsc_pkg::BSC_PH_IDLE;
         end
         default: begin
            s_d.busy = 1'b0;
            s_d.phase = bsc_pkg::BSC_PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign rate_stb = s_q.rate_stb;
   assign rate_act = s_q.rate_act;
   assign mode_stb = s_q.mode_stb;
   assign mode_act = s_q.mode_act;
   assign frame_done = s_q.frame_done;

   a_rate_first: assert property (@(posedge mclk) disable iff (rst)
      rate_stb && ce |=> mode_stb && frame_done)
      else $error("mode step did not follow rate step");
   a_mode_after: assert property (@(posedge mclk) disable iff (rst)
      mode_stb |-> $past(rate_stb))
      else $error("mode step without preceding rate step");
   a_apf_excl: assert property (@(posedge mclk) disable iff (rst)
      rate_stb |-> !(rate_act.apf_resample && rate_act.apf_bypass) &&
      rate_act.apf_bypass == rate_act.apf_fill_mem)
      else $error("post-filter resample and bypass clash");
   a_bpf_rates: assert property (@(posedge mclk) disable iff (rst)
      rate_stb && rate_act.bpf_mem_clear |-> rate_act.fb_resample_dec &&
      bpf_clear_rate(s_q.cur.total_br))
      else $error("bass memory cleared at wrong rate");
   a_legacy_pf: assert property (@(posedge mclk) disable iff (rst)
      rate_stb && rate_act.legacy_clear_uv |-> rate_act.bpf_disable &&
      rate_act.fpf_disable && rate_act.legacy_clear_ext && s_q.cur.legacy)
      else $error("legacy entry actions incomplete");
   a_gain_fade: assert property (@(posedge mclk) disable iff (rst)
      mode_stb |-> mode_act.gain_num == `BSC_W2N_LIM - cnt.w2n)
      else $error("extension gain numerator wrong");
   a_ext_active: assert property (@(posedge mclk) disable iff (rst)
      mode_stb && mode_act.ext_mode != bsc_pkg::BSC_EXT_NONE |-> mode_act.down_active)
      else $error("extension chosen without downswitch");
   a_tde_core: assert property (@(posedge mclk) disable iff (rst)
      mode_stb && s_q.cur.core == bsc_pkg::BSC_TRANSFORM_EXCITED_CORE &&
      mode_act.down_active |-> mode_act.ext_mode == bsc_pkg::BSC_MDCT_PREDICT)
      else $error("transform core did not request prediction");
   a_busy_span: assert property (@(posedge mclk) disable iff (rst)
      rate_stb && ce ##1 ce |=> !busy)
      else $error("frame handling overran three cycles");

   // handshake shape: one take per idle window, strobes are single pulses
   a_take_start: assert property (
      ce && frame_stb && !busy |=> rate_stb && busy)
      else $error("idle strobe was not taken");

   a_take_refuse: assert property (
      ce && frame_stb && busy |=> !rate_stb)
      else $error("strobe taken while busy");

   a_quiet_idle: assert property (
      ce && !frame_stb && !busy |=> !rate_stb && !busy)
      else $error("frame started without a strobe");

   a_strobes_busy: assert property (
      rate_stb || mode_stb |-> busy)
      else $error("frame strobe outside busy window");

   a_busy_end: assert property (
      ce && mode_stb |=> !busy)
      else $error("busy held after mode step");

   a_rate_pulse: assert property (
      ce && rate_stb |=> !rate_stb)
      else $error("rate strobe longer than one cycle");

   a_mode_pulse: assert property (
      ce && mode_stb |=> !mode_stb && !frame_done)
      else $error("mode strobe longer than one cycle");

   a_done_pair: assert property (
      frame_done == mode_stb)
      else $error("frame done apart from mode strobe");

   // actions stand until the next frame replaces them
   a_rate_hold: assert property (
      !rate_stb |-> $stable(rate_act))
      else $error("rate actions changed between frames");

   a_mode_hold: assert property (
      !mode_stb |-> $stable(mode_act))
      else $error("mode actions changed between frames");

   // history load after the take edge, then rate actions checked against the history held before it
   a_hist_load: assert property (
      $rose(rate_stb) |-> s_q.prev_bw == s_q.cur.bw &&
      s_q.prev_br == s_q.cur.total_br && s_q.prev_core == s_q.cur.core)
      else $error("frame history not updated");

   a_reconfig_br: assert property (
      $rose(rate_stb) && rate_act.reconfig |-> s_q.cur.total_br != $past(s_q.prev_br))
      else $error("reconfigure without bitrate change");

   a_reconfig_miss: assert property (
      $rose(rate_stb) && $past(s_q.first_n) &&
      s_q.cur.total_br != $past(s_q.prev_br) |-> rate_act.reconfig)
      else $error("bitrate change without reconfigure");

   a_fb_pair: assert property (
      rate_stb |-> rate_act.fb_resample_dec == rate_act.fb_resample_err)
      else $error("filterbank state sets resampled apart");

   a_apf_resample: assert property (
      $rose(rate_stb) && rate_act.apf_resample |-> $past(s_q.prev_pf_applied) &&
      rate_act.fb_resample_dec)
      else $error("post-filter resampled without prior use");

   a_apf_bypass: assert property (
      $rose(rate_stb) && rate_act.apf_bypass |-> !$past(s_q.prev_pf_applied) &&
      s_q.cur.pf_on && !s_q.prev_pf_applied)
      else $error("post-filter bypass on wrong history");

   a_apf_smooth: assert property (
      $rose(rate_stb) && rate_act.apf_smooth_first |-> $past(s_q.prev_pf_applied) &&
      !s_q.cur.pf_on)
      else $error("smoothing without post-filter turning off");

   a_legacy_entry: assert property (
      $rose(rate_stb) && rate_act.legacy_clear_uv |-> !$past(s_q.prev_legacy) &&
      !s_q.prev_pf_applied)
      else $error("legacy entry actions on wrong frame");

   // mode actions, issued one cycle after the rate actions
   a_core_resample: assert property (
      mode_stb && mode_act.past_core_resample |-> mode_act.mode_trans &&
      s_q.cur.core == bsc_pkg::BSC_TRANSFORM_EXCITED_CORE && rate_act.fb_resample_dec)
      else $error("past core resample without core switch");

   a_flags_track: assert property (
      mode_stb |-> mode_act.down_active == (cnt.w2n != '0) &&
      mode_act.up_active == (cnt.n2w != '0))
      else $error("transition flags disagree with counters");

   a_gain_idle: assert property (
      mode_stb && !mode_act.down_active |-> mode_act.gain_num == `BSC_W2N_LIM)
      else $error("gain faded with no downswitch");

   a_gain_range: assert property (
      mode_stb |-> mode_act.gain_num <= `BSC_W2N_LIM)
      else $error("gain numerator above full scale");

   a_tde_terms: assert property (
      mode_stb && mode_act.ext_mode == bsc_pkg::BSC_TIME_DOMAIN_EXTENSION |->
      s_q.cur.core_br > `BSC_BR_2400 && s_q.cur.coder_type != `BSC_CT_AUDIO &&
      s_q.cur.coder_type != `BSC_CT_INACTIVE)
      else $error("time-domain extension on excluded frame");

   a_ext_terms: assert property (
      mode_stb && (mode_act.ext_mode == bsc_pkg::BSC_TIME_DOMAIN_EXTENSION ||
      mode_act.ext_mode == bsc_pkg::BSC_FREQUENCY_DOMAIN_EXTENSION) |->
      s_q.cur.core == bsc_pkg::BSC_ALGEBRAIC_CORE && !s_q.cur.ppp_mode &&
      s_q.cur.output_sample_rate >= `BSC_FS_32000 &&
      s_q.cur.bw > bsc_pkg::BSC_NARROWBAND_BAND)
      else $error("band extension on excluded frame");
endmodule
`default_nettype wire

// ==== rtl/bsc_cfg.svh ====
// constants for the bandwidth switch control block
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_N2W_INIT 6'h14
`define BSC_W2N_INIT 6'h28
`define BSC_N2W_LIM 6'h14
`define BSC_W2N_LIM 6'h28
`define BSC_CNT_ONE 6'h01
`define BSC_BR_2400 17'h00960
`define BSC_BR_9600 17'h02580
`define BSC_BR_16400 17'h04010
`define BSC_BR_24400 17'h05f50
`define BSC_FS_32000 17'h07d00
`define BSC_CT_AUDIO 3'h1
`define BSC_CT_INACTIVE 3'h2
`endif

// ==== rtl/bsc_pkg.sv ====
// types shared by the bandwidth switch control block
package bsc_pkg;
   typedef enum logic [1:0] {
      BSC_NARROWBAND_BAND = 2'b00,
      BSC_WIDEBAND_BAND = 2'b01,
      BSC_SUPER_WIDEBAND = 2'b10,
      BSC_FULL_BAND = 2'b11
   } bsc_band_e;
   typedef enum logic {
      BSC_ALGEBRAIC_CORE = 1'b0,
      BSC_TRANSFORM_EXCITED_CORE = 1'b1
   } bsc_core_e;
   typedef enum logic [1:0] {
      BSC_EXT_NONE = 2'b00,
      BSC_TIME_DOMAIN_EXTENSION = 2'b01,
      BSC_FREQUENCY_DOMAIN_EXTENSION = 2'b10,
      BSC_MDCT_PREDICT = 2'b11
   } bsc_ext_e;
   typedef enum logic [1:0] {
      BSC_PH_IDLE = 2'b00,
      BSC_PH_RATE = 2'b01,
      BSC_PH_MODE = 2'b10
   } bsc_phase_e;
   typedef struct packed {
      bsc_band_e bw;
      logic [16:0] total_br;
      logic [16:0] core_br;
      bsc_core_e core;
      logic [2:0] coder_type;
      logic [16:0] output_sample_rate;
      logic [1:0] int_rate;
      logic ppp_mode;
      logic pf_on;
      logic legacy;
   } bsc_frame_s;
   typedef struct packed {
      logic [5:0] n2w;
      logic [5:0] w2n;
   } bsc_cnt_s;
   typedef struct packed {
      logic reconfig;
      logic apf_resample;
      logic apf_bypass;
      logic apf_fill_mem;
      logic apf_smooth_first;
      logic bpf_mem_clear;
      logic fb_resample_dec;
      logic fb_resample_err;
      logic legacy_clear_uv;
      logic legacy_clear_ext;
      logic bpf_disable;
      logic fpf_disable;
   } bsc_rate_act_s;
   typedef struct packed {
      logic mode_trans;
      logic past_core_resample;
      bsc_ext_e ext_mode;
      logic [5:0] gain_num;
      logic down_active;
      logic up_active;
   } bsc_mode_act_s;
endpackage

// ==== rtl/bsc_counters.sv ====
// per-frame bandwidth switching counters
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_counters (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic step,
   input wire bsc_pkg::bsc_band_e cur_bw,
   input wire bsc_pkg::bsc_band_e prev_bw,
   input wire logic [16:0] cur_br,
   input wire logic [16:0] prev_br,
   output bsc_pkg::bsc_cnt_s cnt_q
);
   bsc_pkg::bsc_cnt_s cnt_d;

   // both counters stepped in order; the second sees the first's result
   function automatic bsc_pkg::bsc_cnt_s cnt_next(input bsc_pkg::bsc_cnt_s c,
         input bsc_pkg::bsc_band_e cur, input bsc_pkg::bsc_band_e prv,
         input logic [16:0] br, input logic [16:0] pbr);
      bsc_pkg::bsc_cnt_s r;
      r = c;
      if (r.n2w >= `BSC_N2W_LIM) begin
         r.n2w = '0;
      end else if (cur == bsc_pkg::BSC_SUPER_WIDEBAND && br > `BSC_BR_9600 &&
            prv == bsc_pkg::BSC_WIDEBAND_BAND && pbr <= `BSC_BR_9600) begin
         r.n2w = r.n2w + `BSC_CNT_ONE;
      end else if (r.n2w != '0) begin
         if (cur < prv) begin
            r.w2n = ((`BSC_N2W_LIM - r.n2w) << 1) - `BSC_CNT_ONE;
            r.n2w = '0;
         end else begin
            r.n2w = (cur == bsc_pkg::BSC_SUPER_WIDEBAND) ? r.n2w + `BSC_CNT_ONE : '0;
            r.w2n = '0;
         end
      end
      if (r.w2n >= `BSC_W2N_LIM) begin
         r.w2n = '0;
      end else if (br <= `BSC_BR_9600 && pbr > `BSC_BR_9600 && cur < prv &&
            cur == bsc_pkg::BSC_WIDEBAND_BAND) begin
         r.w2n = r.w2n + `BSC_CNT_ONE;
      end else if (r.w2n != '0) begin
         if (cur > prv) begin
            r.n2w = (`BSC_W2N_LIM - r.w2n) >> 1;
            r.w2n = '0;
         end else begin
            r.w2n = (cur == bsc_pkg::BSC_WIDEBAND_BAND) ? r.w2n + `BSC_CNT_ONE : '0;
            r.n2w = '0;
         end
      end
      return r;
   endfunction

   always_comb begin
      cnt_d = cnt_q;
      if (step) begin
         cnt_d = cnt_next(cnt_q, cur_bw, prev_bw, cur_br, prev_br);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= {`BSC_N2W_INIT, `BSC_W2N_INIT};
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end

   a_n2w_wrap: assert property (@(posedge mclk) disable iff (rst)
      ce && step && cnt_q.n2w >= `BSC_N2W_LIM |=> cnt_q.n2w == '0)
      else $error("narrow-to-wide counter did not wrap");
   a_w2n_wrap: assert property (@(posedge mclk) disable iff (rst)
      ce && step && cnt_q.w2n >= `BSC_W2N_LIM |=> cnt_q.w2n == '0)
      else $error("wide-to-narrow counter did not wrap");
   a_count_hold: assert property (@(posedge mclk) disable iff (rst)
      !(ce && step) |=> $stable(cnt_q))
      else $error("counters moved without a frame step");
   a_up_start: assert property (@(posedge mclk) disable iff (rst)
      ce && step && cnt_q == '0 && cur_bw == bsc_pkg::BSC_SUPER_WIDEBAND &&
      cur_br > `BSC_BR_9600 && prev_bw == bsc_pkg::BSC_WIDEBAND_BAND &&
      prev_br <= `BSC_BR_9600 |=> cnt_q.n2w == `BSC_CNT_ONE && cnt_q.w2n == '0)
      else $error("upswitch did not start narrow-to-wide count");
endmodule
`default_nettype wire

// ==== rtl/bsc_ext_sel.sv ====
// upper band regeneration choice during a wide-to-narrow transition
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_ext_sel (
   input wire bsc_pkg::bsc_frame_s frame,
   input wire logic [5:0] w2n,
   output bsc_pkg::bsc_ext_e ext_mode
);
   logic common;

   always_comb begin
      common = frame.core == bsc_pkg::BSC_ALGEBRAIC_CORE &&
         frame.output_sample_rate >= `BSC_FS_32000 &&
         frame.bw > bsc_pkg::BSC_NARROWBAND_BAND && w2n != '0 && !frame.ppp_mode;
      if (frame.core == bsc_pkg::BSC_TRANSFORM_EXCITED_CORE && w2n != '0) begin
         ext_mode = bsc_pkg::BSC_MDCT_PREDICT;
      end else if (common && frame.coder_type != `BSC_CT_AUDIO &&
            frame.coder_type != `BSC_CT_INACTIVE && frame.core_br > `BSC_BR_2400) begin
         ext_mode = bsc_pkg::BSC_TIME_DOMAIN_EXTENSION;
      end else if (common) begin
         ext_mode = bsc_pkg::BSC_FREQUENCY_DOMAIN_EXTENSION;
      end else begin
         ext_mode = bsc_pkg::BSC_EXT_NONE;
      end
   end
endmodule
`default_nettype wire

// ==== verif/bsc_core_model.sv ====
// decoder core stand-in: hands one frame of parameters per request
`timescale 1ns/1ps
`default_nettype none
module bsc_core_model (
   input wire logic mclk,
   input wire logic rate_stb,
   input wire logic frame_done,
   output logic frame_stb,
   output bsc_pkg::bsc_frame_s frame_in,
   output int n_done,
   output int n_rate
);
   initial begin
      frame_stb = 1'b0;
      frame_in = '0;
      n_done = 0;
      n_rate = 0;
   end
   always @(negedge mclk) begin
      if (frame_done === 1'b1) n_done++;
      if (rate_stb === 1'b1) n_rate++;
   end
   // stale parameters are inverted so a late sample cannot pass by luck
   task automatic send(input bsc_pkg::bsc_frame_s f, input int hold, output bit ok);
      int d0;
      d0 = n_done;
      @(posedge mclk);
      frame_stb <= 1'b1;
      frame_in <= f;
      repeat (hold) @(posedge mclk);
      frame_stb <= 1'b0;
      frame_in <= bsc_pkg::bsc_frame_s'(~f);
      for (int i = 0; i < 20 && n_done == d0; i++) @(negedge mclk);
      ok = n_done != d0;
      repeat (3) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== verif/bsc_top_bench.sv ====
// self-checking bench for the bandwidth switch control block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_top_bench;
   localparam bsc_pkg::bsc_band_e b_nar = bsc_pkg::BSC_NARROWBAND_BAND;
   localparam bsc_pkg::bsc_band_e b_wide = bsc_pkg::BSC_WIDEBAND_BAND;
   localparam bsc_pkg::bsc_band_e b_sup = bsc_pkg::BSC_SUPER_WIDEBAND;
   localparam bsc_pkg::bsc_core_e c_alg = bsc_pkg::BSC_ALGEBRAIC_CORE;
   localparam bsc_pkg::bsc_core_e c_tcx = bsc_pkg::BSC_TRANSFORM_EXCITED_CORE;
   localparam logic [16:0] k96 = `BSC_BR_9600;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b0;
   logic frame_stb, busy, rate_stb, mode_stb, frame_done;
   bsc_pkg::bsc_frame_s frame_in, f;
   bsc_pkg::bsc_rate_act_s rate_act;
   bsc_pkg::bsc_mode_act_s mode_act;
   bsc_pkg::bsc_cnt_s cnt;
   int n_done, n_rate;
   int mismatches = 0;
   int n_compared = 0;
   int n_mode = 0;
   // reference history between frames
   logic [5:0] n2w = 6'h14;
   logic [5:0] w2n = 6'h28;
   bsc_pkg::bsc_band_e p_bw = b_nar;
   logic [16:0] p_br = 17'h0;
   logic [1:0] p_ir = 2'h0;
   bsc_pkg::bsc_core_e p_core = c_alg;
   logic p_hist = 1'b0;
   logic p_leg = 1'b0;
   logic first = 1'b1;

   always #10 mclk = ~mclk;
   always @(negedge mclk) if (mode_stb === 1'b1) n_mode++;

   bsc_top i_dut (.mclk(mclk), .rst(rst), .ce(ce), .frame_stb(frame_stb), .frame_in(frame_in),
      .busy(busy), .rate_stb(rate_stb), .rate_act(rate_act), .mode_stb(mode_stb),
      .mode_act(mode_act), .frame_done(frame_done), .cnt(cnt));
   bsc_core_model i_core (.mclk(mclk), .rate_stb(rate_stb), .frame_done(frame_done),
      .frame_stb(frame_stb), .frame_in(frame_in), .n_done(n_done), .n_rate(n_rate));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic run(input int hold);
      bsc_pkg::bsc_rate_act_s er;
      bsc_pkg::bsc_mode_act_s em;
      logic sw, le, byp, ta;
      bit ok;
      int d0;
      // narrow-to-wide steps first, its result feeds the other counter
      if (n2w >= 6'h14) n2w = 6'h0;
      else if (f.bw == b_sup && f.total_br > k96 && p_bw == b_wide && p_br <= k96) n2w++;
      else if (n2w != 6'h0) begin
         if (f.bw < p_bw) begin
            w2n = 6'h27 - (n2w << 1);
            n2w = 6'h0;
         end else begin
            n2w = (f.bw == b_sup) ? n2w + 6'h1 : 6'h0;
            w2n = 6'h0;
         end
      end
      if (w2n >= 6'h28) w2n = 6'h0;
      else if (f.total_br <= k96 && p_br > k96 && f.bw < p_bw && f.bw == b_wide) w2n++;
      else if (w2n != 6'h0) begin
         if (f.bw > p_bw) begin
            n2w = (6'h28 - w2n) >> 1;
            w2n = 6'h0;
         end else begin
            w2n = (f.bw == b_wide) ? w2n + 6'h1 : 6'h0;
            n2w = 6'h0;
         end
      end
      sw = !first && f.int_rate != p_ir;
      le = f.legacy && !p_leg;
      byp = f.pf_on && sw && !p_hist;
      ta = f.output_sample_rate >= `BSC_FS_32000 && f.bw > b_nar && !f.ppp_mode;
      er = '0;
      er.reconfig = !first && f.total_br != p_br;
      er.apf_resample = sw && p_hist;
      er.apf_bypass = byp;
      er.apf_fill_mem = byp;
      er.apf_smooth_first = p_hist && !f.pf_on;
      er.bpf_mem_clear = sw && (f.total_br inside {k96, `BSC_BR_16400, `BSC_BR_24400});
      er.fb_resample_dec = sw;
      er.fb_resample_err = sw;
      {er.legacy_clear_uv, er.legacy_clear_ext, er.bpf_disable, er.fpf_disable} = {4{le}};
      em.mode_trans = !first && f.core != p_core;
      em.past_core_resample = sw && p_core == c_alg && f.core == c_tcx;
      if (w2n == 6'h0) em.ext_mode = bsc_pkg::BSC_EXT_NONE;
      else if (f.core == c_tcx) em.ext_mode = bsc_pkg::BSC_MDCT_PREDICT;
      else if (!ta) em.ext_mode = bsc_pkg::BSC_EXT_NONE;
      else if (f.coder_type != `BSC_CT_AUDIO && f.coder_type != `BSC_CT_INACTIVE
         && f.core_br > `BSC_BR_2400) em.ext_mode = bsc_pkg::BSC_TIME_DOMAIN_EXTENSION;
      else em.ext_mode = bsc_pkg::BSC_FREQUENCY_DOMAIN_EXTENSION;
      em.gain_num = 6'h28 - w2n;
      em.down_active = w2n != 6'h0;
      em.up_active = n2w != 6'h0;
      d0 = n_done;
      i_core.send(f, hold, ok);
      chk("accepted", ok, 1);
      chk("frames", n_done - d0, 1);
      chk("rate pulses", n_rate, n_done);
      chk("mode pulses", n_mode, n_done);
      chk("busy", busy, 0);
      chk("cnt", cnt, {n2w, w2n});
      chk("rate_act", rate_act, er);
      chk("mode_act", mode_act, em);
      p_hist = f.pf_on && !byp && !le;
      p_bw = f.bw;
      p_br = f.total_br;
      p_ir = f.int_rate;
      p_core = f.core;
      p_leg = f.legacy;
      first = 1'b0;
   endtask

   task automatic go(input bsc_pkg::bsc_band_e bw, input logic [16:0] br);
      f.bw = bw;
      f.total_br = br;
      f.core_br = br;
      run(1);
   endtask

   task automatic sc_reset;
      @(negedge mclk);
      chk("cnt", cnt, {6'h14, 6'h28});
      chk("rate_act", rate_act, 0);
      chk("mode_act", mode_act, 0);
      chk("busy", busy, 0);
   endtask

   task automatic sc_up;
      go(b_wide, k96);
      repeat (22) go(b_sup, 17'h03390);
   endtask

   task automatic sc_cross;
      go(b_wide, k96);
      repeat (2) go(b_sup, 17'h03390);
      repeat (6) go(b_wide, k96);
   endtask

   task automatic sc_ext;
      go(b_sup, k96);
      go(b_sup, 17'h03390);
      go(b_wide, k96);
      for (int i = 0; i < 8; i++) begin
         f.coder_type = (i == 1) ? `BSC_CT_AUDIO : (i == 2) ? `BSC_CT_INACTIVE : 3'h0;
         f.output_sample_rate = (i == 4 || i == 7) ? 17'h03e80 : `BSC_FS_32000;
         f.ppp_mode = (i == 5);
         f.core = (i >= 6) ? c_tcx : c_alg;
         go(b_wide, (i == 3) ? `BSC_BR_2400 : k96);
      end
      f.coder_type = 3'h0;
      f.output_sample_rate = `BSC_FS_32000;
      f.core = c_alg;
      go(b_sup, 17'h03390);
   endtask

   task automatic sc_rate;
      f.pf_on = 1'b1;
      go(b_wide, k96);
      f.int_rate = 2'h1;
      go(b_wide, k96);
      f.int_rate = 2'h0;
      f.pf_on = 1'b0;
      f.core = c_tcx;
      go(b_wide, `BSC_BR_16400);
      f.int_rate = 2'h1;
      f.pf_on = 1'b1;
      f.core = c_alg;
      go(b_wide, `BSC_BR_24400);
      f.legacy = 1'b1;
      go(b_wide, `BSC_BR_24400);
      f.legacy = 1'b0;
      f.int_rate = 2'h2;
      go(b_wide, 17'h03390);
   endtask

   // strobe held through the busy cycles must still give one frame
   task automatic sc_refuse;
      f.bw = b_sup;
      f.total_br = 17'h05f50;
      f.core_br = 17'h05f50;
      run(3);
   endtask

   // with the enable low a strobe must leave no trace
   task automatic sc_freeze;
      bit ok;
      int d0;
      d0 = n_rate;
      @(posedge mclk);
      ce <= 1'b0;
      i_core.send(f, 1, ok);
      chk("frozen take", ok, 0);
      chk("frozen rate", n_rate, d0);
      chk("frozen cnt", cnt, {n2w, w2n});
      @(posedge mclk);
      ce <= 1'b1;
      go(b_sup, 17'h05f50);
   endtask

   // a reset in mid-run brings back the start values and drops history
   task automatic sc_rerun;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      n2w = 6'h14;
      w2n = 6'h28;
      p_bw = b_nar;
      p_br = 17'h0;
      p_ir = 2'h0;
      p_core = c_alg;
      p_hist = 1'b0;
      p_leg = 1'b0;
      first = 1'b1;
      sc_reset;
      go(b_wide, k96);
   endtask

   initial begin
      f = '0;
      f.output_sample_rate = `BSC_FS_32000;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      ce <= 1'b1;
      sc_reset;
      sc_up;
      sc_cross;
      sc_ext;
      sc_rate;
      sc_refuse;
      sc_freeze;
      sc_rerun;
      end_sim;
   end

   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      end_sim;
   end
endmodule
`default_nettype wire
